// File: hdl/spindle_ctrl.sv
// Spindle start/stop, output masking, activity lamp and standby power gating.
// Assumes host lines are asynchronous and active low at the pins, the media sensor asynchronous and active high;
// the flux and revolution marker inputs come from on-chip logic on clk_i.
// Behaviour
// - With the spindle stopped, read/write and spindle control power are off.
// - The stepper is powered only during a seek and for 18 ms after the last step.
// - The activity lamp is lit exactly while unit select is low.
// - Flux and marker outputs are masked during a seek and 18 ms after the last step.
// - Flux and marker outputs are masked while not ready, up to 500 ms after start.
// - Media insertion starts the spindle whatever the run request says.
// - About 400 ms after an insertion start the spindle stops unless run is requested.
// - Media removal stops the spindle at once, whatever the run request says.
// - When ready, one active-low marker pulse per revolution, idling high.
// - Status and data outputs are driven only while unit select is low.
// - After a capacity mode change both outputs are masked for 0.5 s.
`timescale 1ns/1ps
module spindle_ctrl
    import spindle_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES   = SETTLE_CYC,
    parameter int unsigned SPINUP_CYCLES   = SPINUP_CYC,
    parameter int unsigned AUTOSTOP_CYCLES = AUTOSTOP_CYC,
    parameter int unsigned MODECHG_CYCLES  = MODECHG_CYC
) (
    // Clock and reset.
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    // Host interface pins, active low.
    input  wire logic      select_n_i,
    input  wire logic      motor_n_i,
    input  wire logic      step_n_i,
    input  wire logic      mode_n_i,
    // Media sensor pin, high while a disk is seated.
    input  wire logic      media_i,
    // Internal read channel on clk_i, active high pulses.
    input  wire logic      flux_i,
    input  wire logic      marker_i,
    // Host outputs, active low, with open-drain enables.
    output host_out_t      host_o,
    output host_out_t      host_oe_o,
    // Lamp and power gating.
    output logic           lamp_o,
    output power_t         power_o
);
    host_in_t    sync1, sync2, sync3, hin;
    logic        media1, media2, media3, media;
    spin_state_t state;
    logic [CNT_W-1:0] auto_cnt, spin_cnt, settle_cnt, mode_cnt;
    logic        spinning, ready, seeking, mode_prev;
    logic        mask, flux_q, marker_q, ready_q, media3_q;

    // Three-stage synchronisers; a change counts when stages two and three agree.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1  <= '0;
            sync2  <= '0;
            sync3  <= '0;
            media1 <= 1'b0;
            media2 <= 1'b0;
            media3 <= 1'b0;
        end else begin
            sync1  <= {~select_n_i, ~motor_n_i, ~step_n_i, ~mode_n_i};
            sync2  <= sync1;
            sync3  <= sync2;
            media1 <= media_i;
            media2 <= media1;
            media3 <= media2;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hin   <= '0;
            media <= 1'b0;
        end else begin
            hin   <= host_in_t'((sync2 & sync3) | (hin & (sync2 | sync3)));
            if (media2 == media3) begin
                media <= media2;
            end
        end
    end

    // Spindle state machine.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state    <= SP_IDLE;
            auto_cnt <= '0;
        end else begin
            case (state)
                SP_IDLE: begin
                    auto_cnt <= '0;
                    // A disk still seated after the spindle stops has no new insertion edge.
                    if (media && hin.motor_req) begin
                        state <= SP_RUN;
                    end
                end
                SP_AUTO: begin
                    auto_cnt <= auto_cnt + 1'b1;
                    if (!media) begin
                        state <= SP_IDLE;
                    end else if (hin.motor_req) begin
                        state <= SP_RUN;
                    end else if (auto_cnt >= CNT_W'(AUTOSTOP_CYCLES - 1)) begin
                        state <= SP_IDLE;
                    end
                end
                SP_RUN: begin
                    if (!media || !hin.motor_req) begin
                        state <= SP_IDLE;
                    end
                end
                default: state <= SP_IDLE;
            endcase
            // Insertion edge takes priority over any run request.
            if (media && !media3_q) begin
                state    <= SP_AUTO;
                auto_cnt <= '0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            media3_q <= 1'b0;
        end else begin
            media3_q <= media;
        end
    end

    assign spinning = (state != SP_IDLE);

    // Spin-up timer; ready only once it has run out.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            spin_cnt <= '0;
        end else if (!spinning) begin
            spin_cnt <= '0;
        end else if (spin_cnt != CNT_W'(SPINUP_CYCLES)) begin
            spin_cnt <= spin_cnt + 1'b1;
        end
    end

    assign ready = media && spinning && (spin_cnt == CNT_W'(SPINUP_CYCLES));

    // Seek tracking: each step restarts the settle window.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            settle_cnt <= '0;
        end else begin
            if (hin.step) begin
                settle_cnt <= CNT_W'(SETTLE_CYCLES);
            end else if (settle_cnt != '0) begin
                settle_cnt <= settle_cnt - 1'b1;
            end
        end
    end

    assign seeking = hin.step || (settle_cnt != '0);

    // Capacity mode change mask.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_prev <= 1'b0;
            mode_cnt  <= '0;
        end else begin
            mode_prev <= hin.mode_hd;
            if (hin.mode_hd != mode_prev && spinning) begin
                mode_cnt <= CNT_W'(MODECHG_CYCLES);
            end else if (mode_cnt != '0) begin
                mode_cnt <= mode_cnt - 1'b1;
            end
        end
    end

    assign mask = seeking || !ready || (mode_cnt != '0);

    // Registered outputs; the lines idle high when masked or deselected.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            flux_q   <= 1'b0;
            marker_q <= 1'b0;
            ready_q  <= 1'b0;
        end else begin
            flux_q   <= hin.select && !mask && flux_i;
            marker_q <= hin.select && !mask && marker_i;
            ready_q  <= hin.select && ready;
        end
    end

    assign host_o    = '0;
    assign host_oe_o = '{read_n: flux_q, index_n: marker_q, ready_n: ready_q};
    assign lamp_o    = hin.select;
    // Gating the stepper off between seeks saves most of the standby current.
    assign power_o   = '{rw_pwr: spinning, spindle_pwr: spinning,
                         stepper_pwr: seeking};

    AST_STOP_PWR: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == SP_IDLE) |-> !power_o.rw_pwr && !power_o.spindle_pwr)
        else $error("power on with spindle stopped");
    AST_STEP_PWR: assert property (@(posedge clk_i) disable iff (rst_i)
        power_o.stepper_pwr |-> seeking)
        else $error("stepper powered outside a seek");
    AST_LAMP: assert property (@(posedge clk_i) disable iff (rst_i)
        (sync2.select == sync3.select) |=> lamp_o == $past(sync3.select))
        else $error("lamp does not follow select");
    AST_SEEK_MASK: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(hin.step) |=> !host_oe_o.read_n [*8])
        else $error("flux not masked after step");
    AST_SPINUP_MASK: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(spinning) |=> !host_oe_o.index_n [*8])
        else $error("marker not masked at spin-up");
    AST_INSERT: assert property (@(posedge clk_i) disable iff (rst_i)
        (media && !media3_q) |=> state == SP_AUTO)
        else $error("insertion did not start spindle");
    AST_REMOVE: assert property (@(posedge clk_i) disable iff (rst_i)
        (!media && $past(media)) |=> !spinning)
        else $error("removal did not stop spindle");
    AST_DESEL: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(hin.select) |-> host_oe_o == '0)
        else $error("outputs driven while deselected");
    AST_READY: assert property (@(posedge clk_i) disable iff (rst_i)
        ready |-> media && spinning)
        else $error("ready without media and spindle");

    COV_INSERT: cover property (@(posedge clk_i) disable iff (rst_i)
        state == SP_AUTO ##1 state == SP_IDLE);
    COV_RUN:    cover property (@(posedge clk_i) disable iff (rst_i)
        state == SP_AUTO ##1 state == SP_RUN);
    COV_READY:  cover property (@(posedge clk_i) disable iff (rst_i) $rose(ready));
endmodule

// File: common/spindle_pkg.sv
// Shared constants and carriers for the spindle, mask and power control block.
// Assumes a 100 MHz clock; all times are converted to cycle counts here.
package spindle_pkg;
    localparam int unsigned CLK_HZ         = 100_000_000;
    localparam int unsigned SETTLE_MS      = 18;
    localparam int unsigned SPINUP_MS      = 500;
    localparam int unsigned AUTOSTOP_MS    = 400;
    localparam int unsigned MODECHG_MS     = 500;
    // Times convert to whole cycles exactly; 27 counter bits hold the longest.
    localparam int unsigned SETTLE_CYC     = SETTLE_MS * (CLK_HZ / 1000);
    localparam int unsigned SPINUP_CYC     = SPINUP_MS * (CLK_HZ / 1000);
    localparam int unsigned AUTOSTOP_CYC   = AUTOSTOP_MS * (CLK_HZ / 1000);
    localparam int unsigned MODECHG_CYC    = MODECHG_MS * (CLK_HZ / 1000);
    localparam int unsigned CNT_W          = 27;

    typedef enum logic [2:0] {
        SP_IDLE = 3'h1,
        SP_AUTO = 3'h2,
        SP_RUN  = 3'h4
    } spin_state_t;

    // Host-side lines after synchronisation, active high.
    typedef struct packed {
        logic select;
        logic motor_req;
        logic step;
        logic mode_hd;
    } host_in_t;

    // Drive-side outputs to the host connector, active low, open-drain sense.
    typedef struct packed {
        logic read_n;
        logic index_n;
        logic ready_n;
    } host_out_t;

    // Power gating enables to the analog sections, active high.
    typedef struct packed {
        logic rw_pwr;
        logic spindle_pwr;
        logic stepper_pwr;
    } power_t;
endpackage

// File: tb/host_model.sv
// Host controller model: drives the active-low control pins, resolves the output lines.
// Assumes pull-ups on the lines, so a line that is released reads high.
`timescale 1ns/1ps
module host_model
    import spindle_pkg::*;
#(
    parameter int unsigned HOLDOFF = 20
) (
    // Clock and drive outputs.
    input  wire logic      clk_i,
    input  wire host_out_t host_i,
    input  wire host_out_t oe_i,
    // Control pins and resolved lines.
    output logic           select_n_o,
    output logic           motor_n_o,
    output logic           step_n_o,
    output logic           mode_n_o,
    output host_out_t      line_o
);
    int unsigned motor_age = 0;

    // Open drain with pull-ups: low only while enabled.
    assign line_o = ~oe_i | host_i;

    initial begin
        select_n_o = 1'b1;
        motor_n_o = 1'b1;
        step_n_o = 1'b1;
        mode_n_o = 1'b1;
    end

    always @(posedge clk_i) motor_age <= motor_n_o ? 0 : motor_age + 1;

    task automatic drive(input logic sel, input logic mot, input logic mode);
        @(posedge clk_i);
        #1;
        select_n_o = ~sel;
        motor_n_o = ~mot;
        mode_n_o = ~mode;
    endtask

    // Stepping at once after a motor request would add seek current to the start surge.
    task automatic step_pulse();
        while (!motor_n_o && motor_age < HOLDOFF) @(posedge clk_i);
        @(posedge clk_i);
        #1;
        step_n_o = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        step_n_o = 1'b1;
    endtask
endmodule

// File: tb/spindle_ctrl_test.sv
// Self-checking bench for the spindle, mask and power control block.
// Assumes shortened timer parameters so that the whole run takes a few hundred cycles.
`timescale 1ns/1ps
module spindle_ctrl_test;
    import spindle_pkg::*;
    localparam int unsigned SETTLE = 20;
    localparam int unsigned SPINUP = 50;
    localparam int unsigned AUTOSTOP = 40;
    localparam int unsigned MODECHG = 50;
    logic      clk_i = 1'b0;
    logic      rst_i = 1'b1;
    logic      media = 1'b0;
    logic      flux = 1'b0;
    logic      marker = 1'b0;
    logic      select_n, motor_n, step_n, mode_n, lamp;
    host_out_t host, host_oe, line;
    power_t    power;
    int        fail_count = 0;
    int        checks_done = 0;
    int        cycles = 0;

    always #5 clk_i = ~clk_i;

    spindle_ctrl #(.SETTLE_CYCLES(SETTLE), .SPINUP_CYCLES(SPINUP),
        .AUTOSTOP_CYCLES(AUTOSTOP), .MODECHG_CYCLES(MODECHG)) spindle_ctrl_inst (
        .clk_i(clk_i), .rst_i(rst_i), .select_n_i(select_n), .motor_n_i(motor_n),
        .step_n_i(step_n), .mode_n_i(mode_n), .media_i(media), .flux_i(flux),
        .marker_i(marker), .host_o(host), .host_oe_o(host_oe), .lamp_o(lamp),
        .power_o(power));

    host_model #(.HOLDOFF(20)) host_model_inst (.clk_i(clk_i), .host_i(host),
        .oe_i(host_oe), .select_n_o(select_n), .motor_n_o(motor_n), .step_n_o(step_n),
        .mode_n_o(mode_n), .line_o(line));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // The ceiling sits far above the few hundred cycles the tests need.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic compare(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Pulses one read channel input and checks whether its line went low.
    task automatic probe(input logic index, input logic exp, input string what);
        logic seen;
        seen = 1'b0;
        if (index) begin
            marker = 1'b1;
        end else begin
            flux = 1'b1;
        end
        ticks(1);
        // The registered line stands for one cycle only, so look before clearing.
        seen |= index ? ~line.index_n : ~line.read_n;
        marker = 1'b0;
        flux = 1'b0;
        repeat (4) begin
            ticks(1);
            seen |= index ? ~line.index_n : ~line.read_n;
        end
        compare(seen, exp, what);
    endtask

    task automatic t_reset_lamp();
        compare(|power, 1'b0, "power on after reset");
        compare(|host_oe, 1'b0, "line driven after reset");
        host_model_inst.drive(1'b1, 1'b0, 1'b0);
        ticks(8);
        compare(lamp, 1'b1, "lamp dark while selected");
        host_model_inst.drive(1'b0, 1'b0, 1'b0);
        ticks(8);
        compare(lamp, 1'b0, "lamp lit while deselected");
        $display("test reset_lamp done");
    endtask

    task automatic t_auto_stop();
        host_model_inst.drive(1'b1, 1'b0, 1'b0);
        media = 1'b1;
        ticks(8);
        compare(power.spindle_pwr, 1'b1, "no start on insertion");
        compare(power.rw_pwr, 1'b1, "read power off while spinning");
        probe(1'b0, 1'b0, "flux passed during spin-up");
        ticks(AUTOSTOP);
        compare(power.spindle_pwr, 1'b0, "no auto stop");
        compare(power.rw_pwr, 1'b0, "read power on while stopped");
        media = 1'b0;
        ticks(8);
        $display("test auto_stop done");
    endtask

    task automatic t_run_ready();
        host_model_inst.drive(1'b1, 1'b1, 1'b0);
        media = 1'b1;
        ticks(20);
        compare(line.ready_n, 1'b1, "ready during spin-up");
        probe(1'b0, 1'b0, "flux passed while not ready");
        ticks(AUTOSTOP + 20);
        compare(power.spindle_pwr, 1'b1, "stopped with run request");
        compare(line.ready_n, 1'b0, "not ready after spin-up");
        compare(line.index_n, 1'b1, "marker line not idle high");
        probe(1'b1, 1'b1, "marker not passed when ready");
        probe(1'b0, 1'b1, "flux not passed when ready");
        $display("test run_ready done");
    endtask

    task automatic t_seek();
        logic seen;
        compare(power.stepper_pwr, 1'b0, "stepper powered while idle");
        host_model_inst.step_pulse();
        seen = 1'b0;
        repeat (10) begin
            ticks(1);
            seen |= power.stepper_pwr;
        end
        compare(seen, 1'b1, "stepper unpowered in seek");
        probe(1'b0, 1'b0, "flux passed while settling");
        ticks(SETTLE + 10);
        compare(power.stepper_pwr, 1'b0, "stepper powered after seek");
        probe(1'b1, 1'b1, "marker held after settling");
        $display("test seek done");
    endtask

    task automatic t_mode_deselect_remove();
        host_model_inst.drive(1'b1, 1'b1, 1'b1);
        ticks(8);
        probe(1'b0, 1'b0, "flux passed after mode change");
        ticks(MODECHG);
        probe(1'b0, 1'b1, "flux held after mode delay");
        host_model_inst.drive(1'b0, 1'b1, 1'b1);
        ticks(8);
        probe(1'b1, 1'b0, "marker driven while deselected");
        compare(line.ready_n, 1'b1, "ready driven while deselected");
        host_model_inst.drive(1'b0, 1'b0, 1'b1);
        ticks(8);
        compare(power.rw_pwr, 1'b0, "read power on with run dropped");
        host_model_inst.drive(1'b0, 1'b1, 1'b1);
        ticks(8);
        compare(power.rw_pwr, 1'b1, "read power off after run request");
        media = 1'b0;
        ticks(8);
        compare(power.spindle_pwr, 1'b0, "spindle runs after removal");
        compare(power.rw_pwr, 1'b0, "read power on after removal");
        $display("test mode_deselect_remove done");
    endtask

    initial begin
        ticks(8);
        rst_i = 1'b0;
        ticks(2);
        t_reset_lamp();
        t_auto_stop();
        t_run_ready();
        t_seek();
        t_mode_deselect_remove();
        tally_and_finish();
    end
endmodule
